// ==== rtl/srw_pkg.sv ====
// constants for the supervisory reset and watchdog block
package srw_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned TICK_HZ = 1000;
	localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int unsigned RESET_HOLD_MS = 140;
	localparam int unsigned RESET_HOLD_TICKS = (RESET_HOLD_MS * TICK_HZ + 999) / 1000;
	localparam int unsigned WDOG_TIMEOUT_MS = 1120;
	localparam int unsigned WDOG_TIMEOUT_TICKS = (WDOG_TIMEOUT_MS * TICK_HZ + 999) / 1000;
	localparam int unsigned CNT_W = 24;
endpackage

// ==== rtl/srw_supervisor.sv ====
// supervisory reset generator with watchdog and manual reset
// Functional notes
// - reset held while supply low, then held at least 140 ms after it recovers
// - reset when watchdog input fails to change state within the timeout
// - manual reset request low starts a reset; it idles high
// - floating watchdog input disables the watchdog, no watchdog reset
// - active-low reset output driven low during reset, high otherwise
// - active-high reset output is always the inverse of the active-low one
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor
	import srw_pkg::*;
#(
	parameter int unsigned TICK_DIV_P = TICK_DIV,
	parameter int unsigned HOLD_TICKS_P = RESET_HOLD_TICKS,
	parameter int unsigned WDOG_TICKS_P = WDOG_TIMEOUT_TICKS
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic supply_ok,
	input wire logic manual_reset_request_n,
	input wire logic watchdog_kick_input,
	input wire logic watchdog_kick_driven,
	output logic reset_out_n,
	output logic reset_out
);
	// elaboration guard: counters reach the full count, so it must fit
	if (TICK_DIV_P < 1 || HOLD_TICKS_P < 1 || WDOG_TICKS_P < 2) begin : g_too_small
		$error("srw_supervisor: counts too small");
	end
	if (TICK_DIV_P >= (1 << CNT_W) || HOLD_TICKS_P >= (1 << CNT_W)
		|| WDOG_TICKS_P >= (1 << CNT_W)) begin : g_too_wide
		$error("srw_supervisor: counts exceed counter width");
	end

	localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(TICK_DIV_P - 1);
	localparam logic [CNT_W-1:0] HOLD_N = CNT_W'(HOLD_TICKS_P);
	localparam logic [CNT_W-1:0] WDOG_N = CNT_W'(WDOG_TICKS_P);

	// pin synchronisers, first stage read only by second
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sync1 <= 4'h2;
			sync2 <= 4'h2;
		end else begin
			sync1 <= {watchdog_kick_driven, watchdog_kick_input, manual_reset_request_n,
				supply_ok};
			sync2 <= sync1;
		end
	end
	wire supply_good = sync2[0];
	wire manual_low = !sync2[1];
	wire kick = sync2[2];
	wire kick_en = sync2[3];

	logic kick_q;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			kick_q <= 1'b0;
		end else begin
			kick_q <= kick;
		end
	end
	wire kick_edge = kick_en && (kick != kick_q);

	// timebase tick
	logic [CNT_W-1:0] div_cnt;
	wire tick = (div_cnt == DIV_LAST);
	always_ff @(posedge mclk) begin
		if (!rst_b || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	typedef enum logic [1:0] {SRW_HOLD, SRW_EXTEND, SRW_RUN} srw_state_e;
	srw_state_e state;
	srw_state_e next_state;
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] wdog_cnt;

	// first tick after a restart is partial; one extra tick keeps each minimum
	wire wdog_expired = kick_en && (wdog_cnt >= WDOG_N) && tick;
	wire trigger = !supply_good || manual_low || wdog_expired;
	wire hold_done = tick && (hold_cnt >= HOLD_N);

	always_comb begin
		next_state = state;
		unique case (state)
			SRW_HOLD: begin
				if (supply_good && !manual_low) begin
					next_state = SRW_EXTEND;
				end
			end
			SRW_EXTEND: begin
				if (!supply_good || manual_low) begin
					next_state = SRW_HOLD;
				end else if (hold_done) begin
					next_state = SRW_RUN;
				end
			end
			SRW_RUN: begin
				if (trigger) begin
					next_state = SRW_HOLD;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= SRW_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// extension counter restarts whenever a cause is present
	always_ff @(posedge mclk) begin
		if (!rst_b || state != SRW_EXTEND) begin
			hold_cnt <= '0;
		end else if (tick) begin
			hold_cnt <= hold_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b || state != SRW_RUN || kick_edge || !kick_en) begin
			wdog_cnt <= '0;
		end else if (tick) begin
			wdog_cnt <= wdog_cnt + 1'b1;
		end
	end

	logic in_reset;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			in_reset <= 1'b1;
		end else begin
			in_reset <= (next_state != SRW_RUN);
		end
	end
	assign reset_out_n = !in_reset;
	assign reset_out = in_reset;

	property p_complement;
		@(posedge mclk) disable iff (!rst_b) reset_out == !reset_out_n;
	endproperty
	a_complement: assert property (p_complement)
		else $error("reset outputs not complementary");

	property p_supply_low;
		@(posedge mclk) disable iff (!rst_b) !supply_good |=> !reset_out_n;
	endproperty
	a_supply_low: assert property (p_supply_low)
		else $error("reset not asserted on low supply");

	property p_manual;
		@(posedge mclk) disable iff (!rst_b) manual_low |=> !reset_out_n;
	endproperty
	a_manual: assert property (p_manual)
		else $error("manual reset ignored");

	property p_release_hold;
		@(posedge mclk) disable iff (!rst_b)
			$rose(reset_out_n) |-> $past(state == SRW_EXTEND) && $past(hold_done);
	endproperty
	a_release_hold: assert property (p_release_hold)
		else $error("reset released early");

	property p_wdog_fire;
		@(posedge mclk) disable iff (!rst_b) (state == SRW_RUN && wdog_expired) |=> reset_out;
	endproperty
	a_wdog_fire: assert property (p_wdog_fire)
		else $error("watchdog timeout missed");

	property p_wdog_disabled;
		@(posedge mclk) disable iff (!rst_b)
			(state == SRW_RUN && !kick_en && supply_good && !manual_low) |=> !reset_out;
	endproperty
	a_wdog_disabled: assert property (p_wdog_disabled)
		else $error("disabled watchdog fired");

	property p_wdog_restart;
		@(posedge mclk) disable iff (!rst_b) kick_edge |=> wdog_cnt == '0;
	endproperty
	a_wdog_restart: assert property (p_wdog_restart)
		else $error("watchdog not restarted");

	property p_release_fresh;
		@(posedge mclk) disable iff (!rst_b) $rose(reset_out_n) |-> wdog_cnt == '0;
	endproperty
	a_release_fresh: assert property (p_release_fresh)
		else $error("stale watchdog count");

	property p_release_count;
		@(posedge mclk) disable iff (!rst_b) $rose(reset_out_n) |-> $past(hold_cnt) == HOLD_N;
	endproperty
	a_release_count: assert property (p_release_count)
		else $error("extension shorter than its tick count");

	property p_hold_restart;
		@(posedge mclk) disable iff (!rst_b)
			(state == SRW_EXTEND && (!supply_good || manual_low)) |=> (state == SRW_HOLD && reset_out);
	endproperty
	a_hold_restart: assert property (p_hold_restart)
		else $error("extension not restarted by a cause");

	property p_run_quiet;
		@(posedge mclk) disable iff (!rst_b) (state == SRW_RUN && !trigger) |=> reset_out_n;
	endproperty
	a_run_quiet: assert property (p_run_quiet)
		else $error("reset held with no cause");

	property p_disabled_idle;
		@(posedge mclk) disable iff (!rst_b) !kick_en |=> wdog_cnt == '0;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("disabled watchdog still counting");
endmodule
`default_nettype wire

// ==== bench/srw_cpu_model.sv ====
// processor model driving the watchdog pin
`timescale 1ns/1ps
`default_nettype none
module srw_cpu_model (
	input wire logic mclk,
	input wire logic reset_out_n,
	input wire logic kick_on,
	input wire logic float_pin,
	output logic kick,
	output logic driven
);
	logic [2:0] cnt = 3'h0;
	logic lvl = 1'b0;
	// released pin parks opposite its last level; only the drive flag says it floats
	assign driven = ~float_pin;
	assign kick = float_pin ? ~lvl : lvl;
	always @(posedge mclk) begin
		cnt <= cnt + 3'h1;
		if (kick_on && reset_out_n && cnt == 3'h7) begin
			lvl <= ~lvl;
		end
	end
endmodule
`default_nettype wire

// ==== bench/supervisory_reset_watchdog_tb.sv ====
// testbench for the supervisory reset block
`timescale 1ns/1ps
`default_nettype none
module supervisory_reset_watchdog_tb;
	logic mclk = 0, rst_b = 0, supply_ok = 0, mr_n = 1, kick_on = 0, float_pin = 0;
	wire logic kick, driven, rn, r;
	int fails = 0, tests_run = 0;
	// short counts keep the run brief; expectations below scale with them
	localparam int TB_DIV = 4;
	localparam int TB_HOLD = 3;
	localparam int TB_WDOG = 5;
	// minimum extension after a pin cause clears, two sync stages included
	localparam int TB_MIN_HOLD = TB_HOLD * TB_DIV + 2;
	srw_supervisor #(.TICK_DIV_P(TB_DIV), .HOLD_TICKS_P(TB_HOLD), .WDOG_TICKS_P(TB_WDOG)) dut_u (
		.mclk(mclk), .rst_b(rst_b), .supply_ok(supply_ok),
		.manual_reset_request_n(mr_n), .watchdog_kick_input(kick),
		.watchdog_kick_driven(driven), .reset_out_n(rn), .reset_out(r));
	srw_cpu_model cpu_u (.mclk(mclk), .reset_out_n(rn), .kick_on(kick_on),
		.float_pin(float_pin), .kick(kick), .driven(driven));
	initial forever #4 mclk = ~mclk;
	task automatic chk(input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// still held after min_c cycles, then free within a bound
	task automatic held_then_free(input int min_c);
		int k;
		cyc(min_c);
		chk(rn, 1'b0);
		for (k = 0; k < 40 && rn !== 1'b1; k++) cyc(1);
		chk(rn, 1'b1);
		chk(r, 1'b0);
	endtask
	task automatic t_power();
		cyc(20);
		chk(rn, 1'b0);
		chk(r, 1'b1);
		supply_ok = 1;
		held_then_free(TB_MIN_HOLD);
		$display("power-up test done");
	endtask
	task automatic t_brownout();
		supply_ok = 0;
		cyc(4);
		chk(rn, 1'b0);
		cyc(30);
		chk(r, 1'b1);
		supply_ok = 1;
		held_then_free(TB_MIN_HOLD);
		$display("brownout test done");
	endtask
	task automatic t_manual();
		mr_n = 0;
		cyc(4);
		chk(r, 1'b1);
		mr_n = 1;
		held_then_free(TB_MIN_HOLD);
		// a press during the extension must restart it in full
		mr_n = 0;
		cyc(4);
		chk(r, 1'b1);
		mr_n = 1;
		cyc(TB_DIV * 2);
		mr_n = 0;
		cyc(4);
		chk(rn, 1'b0);
		mr_n = 1;
		held_then_free(TB_MIN_HOLD);
		$display("manual test done");
	endtask
	task automatic t_watchdog();
		int k;
		kick_on = 1;
		cyc(100);
		chk(rn, 1'b1);
		kick_on = 0;
		// last kick may be one model period old, so one tick short of the timeout
		cyc((TB_WDOG - 1) * TB_DIV);
		chk(rn, 1'b1);
		for (k = 0; k < 40 && rn !== 1'b0; k++) cyc(1);
		chk(rn, 1'b0);
		// internal cause: no pin sync ahead of the extension
		held_then_free(TB_HOLD * TB_DIV);
		// fresh interval after release, no early bite
		cyc(10);
		chk(rn, 1'b1);
		float_pin = 1;
		cyc(100);
		chk(rn, 1'b1);
		$display("watchdog test done");
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		cyc(6);
		rst_b = 1;
		t_power();
		t_brownout();
		t_manual();
		t_watchdog();
		finish_test();
	end
	initial begin
		#20000;
		fails++;
		finish_test();
	end
endmodule
`default_nettype wire
